// [panel_decode_pkg.sv]
// Shared constants for the panel processor bus glue
package panel_decode_pkg;
  // Clock and timing
  localparam int CLK_FREQ_HZ     = 100_000_000;
  localparam int SUPPLY_HOLD_MS  = 50;
  localparam int HOLD_CYCLES     = SUPPLY_HOLD_MS * (CLK_FREQ_HZ / 1000);
  localparam int E_RESET_CYCLES  = 4064;
  localparam int E_CNT_W         = 12;
  localparam int HOLD_CNT_W      = 32;
  // Address field positions within the 8-bit high address byte
  localparam int ADDR_TOP_BIT    = 7;   // A15
  localparam int ADDR_RAM_BIT    = 6;   // A14
  localparam int BLOCK_MSB       = 5;   // A13
  localparam int BLOCK_LSB       = 3;   // A11
  // Strobes and widths
  localparam int IO_BLOCKS       = 8;
  localparam int SWITCH_SEL      = 6;
  localparam int IDENT_SEL       = 7;
  localparam int LAMP_SELS       = 4;
  localparam int SWITCH_W        = 10;
  localparam int IDENT_W         = 6;
  localparam int SWITCH_LOW_W    = 8;
  localparam int SWITCH_HIGH_LSB = 8;
  localparam int SYNC_W          = 39;
  localparam int ENC_CNT_W       = 8;
  // Reset values and the RAM address field value
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] SEL_IDLE_N = 8'hFF;
  localparam logic [1:0] RAM_FIELD  = 2'h1;
endpackage : panel_decode_pkg

// [reset_hold.sv]
// Processor reset generator: power-up and supply-loss hold
`timescale 1ns/1ps
module reset_hold
  import panel_decode_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYCLES,
  parameter int E_CYC    = E_RESET_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic supplyGood,
  input  wire logic eRise,
  output logic      cpuReset_n
);
  logic [E_CNT_W-1:0]    eCnt_r;
  logic [HOLD_CNT_W-1:0] tCnt_r;
  logic                  eDone;
  logic                  tDone;

  if (HOLD_CYC < 1 || E_CYC < 1 || E_CYC >= (1 << E_CNT_W)) begin : g_chk
    $error("reset_hold: hold counts out of range");
  end

  assign eDone = (eCnt_r == E_CYC[E_CNT_W-1:0]);
  assign tDone = (tCnt_r == HOLD_CYC[HOLD_CNT_W-1:0]);

  // Count bus clock cycles, restarting whenever the supply drops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eCnt_r <= '0;
    end else if (!supplyGood) begin
      eCnt_r <= '0;
    end else if (eRise && !eDone) begin
      eCnt_r <= eCnt_r + {{(E_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Count the supply-good hold time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tCnt_r <= '0;
    end else if (!supplyGood) begin
      tCnt_r <= '0;
    end else if (!tDone) begin
      tCnt_r <= tCnt_r + {{(HOLD_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Release only after both holds have run out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuReset_n <= 1'b0;
    end else begin
      cpuReset_n <= supplyGood && eDone && tDone;
    end
  end

  property p_releaseAfterHold;
    @(posedge mclk) disable iff (!rst_n)
      $rose(cpuReset_n) |-> $past(eCnt_r) == E_CYC[E_CNT_W-1:0]
                            && $past(tCnt_r) == HOLD_CYC[HOLD_CNT_W-1:0];
  endproperty
  a_releaseAfterHold: assert property (p_releaseAfterHold)
    else $error("processor reset released before hold expired");

  property p_supplyLoss;
    @(posedge mclk) disable iff (!rst_n)
      !supplyGood |=> !cpuReset_n ##1 !cpuReset_n;
  endproperty
  a_supplyLoss: assert property (p_supplyLoss)
    else $error("reset not held after supply loss");
endmodule : reset_hold

// [quad_decode.sv]
// Quadrature encoder input synchroniser and direction decoder
`timescale 1ns/1ps
module quad_decode
  import panel_decode_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 encoderPhaseA,
  input  wire logic                 encoderPhaseB,
  output logic                      encStep,
  output logic                      encDir,
  output logic [ENC_CNT_W-1:0]      encCount
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;
  logic       valid;
  logic       dirNow;

  // Two-stage synchroniser on both phases
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
    end else begin
      meta_r <= {encoderPhaseA, encoderPhaseB};
      sync_r <= meta_r;
    end
  end

  // A legal step changes exactly one phase
  assign valid  = ^(sync_r ^ prev_r);
  assign dirNow = prev_r[1] ^ sync_r[0];

  // Step pulse, direction and position count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r   <= 2'h0;
      encStep  <= 1'b0;
      encDir   <= 1'b0;
      encCount <= '0;
    end else begin
      prev_r  <= sync_r;
      encStep <= valid;
      if (valid) begin
        encDir   <= dirNow;
        encCount <= dirNow ? encCount + {{(ENC_CNT_W-1){1'b0}}, 1'b1}
                           : encCount - {{(ENC_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  property p_dirTracks;
    @(posedge mclk) disable iff (!rst_n)
      encStep |-> encDir == ($past(prev_r[1]) ^ $past(sync_r[0]));
  endproperty
  a_dirTracks: assert property (p_dirTracks)
    else $error("encoder direction disagrees with phase order");
endmodule : quad_decode

// [panel_cpu_bus_decode.sv]
// Processor bus glue: reset, RAM and I/O selects, read mux, serial selects
// Notes on behaviour
// - Hold processor reset low at least 4064 bus clock cycles after power-up.
// - Assert reset on supply loss; hold 50 ms after supply returns good.
// - First RAM select is active low and follows address bit fifteen.
// - Second RAM select is high only when A14 and E are high.
// - RAM answers only at 4000h-7FFFh, mirrored at 4000h and 6000h.
// - Write enable goes low only in second half of write cycles.
// - Four separate active-low LED driver selects, one asserted at most.
// - Transmit enable high drives RS-485 bus; low releases it.
// - Transmit enable held deasserted throughout reset and power-up.
// - I/O decoder enabled only with A15, A14 low and E high.
// - Eight active-low 2K select strobes from 0000h up to 3800h.
// - Seventh strobe read returns eight address switch bits, closed reads low.
// - Eighth strobe read returns two switch bits plus six ID bits.
// - Encoder direction derived from the relative phase of two inputs.
// - Bus E clock is quarter of master oscillator and times bus cycles.
// - Low address byte latched on falling address strobe, held until next.
// - Second half carries write data in, or read data out.
`timescale 1ns/1ps
module panel_cpu_bus_decode
  import panel_decode_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYCLES
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 supplyGood,
  input  wire logic                 eClk,
  input  wire logic                 addrLatchStrobe,
  input  wire logic                 rdWr,
  input  wire logic [7:0]           addrHigh,
  input  wire logic [7:0]           portIn,
  output logic      [7:0]           portOut,
  output logic                      portOe,
  output logic      [7:0]           addrLow,
  output logic                      cpuReset_n,
  output logic                      ramSelLow_n,
  output logic                      ramSelHigh,
  output logic                      writeEnable_n,
  output logic      [IO_BLOCKS-1:0] ioBlockSel_n,
  input  wire logic [SWITCH_W-1:0]  addrSwitchBits,
  input  wire logic [IDENT_W-1:0]   identBits,
  input  wire logic [1:0]           lampSelIdx,
  input  wire logic                 lampSelActive,
  output logic      [LAMP_SELS-1:0] lampDriverSel_n,
  input  wire logic                 txEnableReq,
  output logic                      txEnable,
  input  wire logic                 encoderPhaseA,
  input  wire logic                 encoderPhaseB,
  output logic                      encStep,
  output logic                      encDir,
  output logic      [ENC_CNT_W-1:0] encCount
);
  logic [SYNC_W-1:0]   pinBus;
  logic [SYNC_W-1:0]   sync_r;
  logic [7:0]          aHi;
  logic [7:0]          portS;
  logic [SWITCH_W-1:0] swS;
  logic [IDENT_W-1:0]  idS;
  logic [1:0]          lampIdxS;
  logic                eS;
  logic                asS;
  logic                rwS;
  logic                lampEnS;
  logic                txReqS;
  logic                eDly_r;
  logic                asDly_r;
  logic                eRise;
  logic                ioEnable;
  logic [IO_BLOCKS-1:0] blockHit;
  logic                readSwitch;
  logic                readIdent;
  logic                supplyMeta_r;
  logic                supplyGoodS;

  if (IO_BLOCKS != 8 || LAMP_SELS != 4 || SYNC_W != 39) begin : g_chk
    $error("panel_cpu_bus_decode: decoder shape not supported");
  end

  // One-hot 2K block select from the high address byte
  function automatic logic [IO_BLOCKS-1:0] blockDecode(input logic [7:0] hi);
    logic [IO_BLOCKS-1:0] oh;
    oh = '0;
    oh[hi[BLOCK_MSB:BLOCK_LSB]] = 1'b1;
    return oh;
  endfunction : blockDecode

  // Pin inputs gathered into one word for the synchroniser
  assign pinBus = {txEnableReq, lampSelActive, lampSelIdx, identBits,
                   addrSwitchBits, portIn, rdWr, addrLatchStrobe, eClk,
                   addrHigh};

  // Two-stage synchroniser for every pin input gathered in pinBus, one pair of flops per bit
  genvar gi;
  for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
    logic stage1_r;
    logic stage2_r;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        stage1_r <= 1'b0;
        stage2_r <= 1'b0;
      end else begin
        stage1_r <= pinBus[gi];
        stage2_r <= stage1_r;
      end
    end
    assign sync_r[gi] = stage2_r;
  end

  assign aHi      = sync_r[7:0];
  assign eS       = sync_r[8];
  assign asS      = sync_r[9];
  assign rwS      = sync_r[10];
  assign portS    = sync_r[18:11];
  assign swS      = sync_r[28:19];
  assign idS      = sync_r[34:29];
  assign lampIdxS = sync_r[36:35];
  assign lampEnS  = sync_r[37];
  assign txReqS   = sync_r[38];

  // Edge history of the bus clock and address strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eDly_r  <= 1'b0;
      asDly_r <= 1'b0;
    end else begin
      eDly_r  <= eS;
      asDly_r <= asS;
    end
  end

  assign eRise = eS && !eDly_r;

  // Low address byte latch on the falling address strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addrLow <= DATA_RST;
    end else if (asDly_r && !asS) begin
      addrLow <= portS;
    end
  end

  // Processor reset generator
  reset_hold #(
    .HOLD_CYC (HOLD_CYC),
    .E_CYC    (E_RESET_CYCLES)
  ) u_reset (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .supplyGood (supplyGoodS),
    .eRise      (eRise),
    .cpuReset_n (cpuReset_n)
  );

  // Supply-good level crosses in through its own two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supplyMeta_r <= 1'b0;
      supplyGoodS  <= 1'b0;
    end else begin
      supplyMeta_r <= supplyGood;
      supplyGoodS  <= supplyMeta_r;
    end
  end

  // RAM selects and write enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ramSelLow_n   <= 1'b1;
      ramSelHigh    <= 1'b0;
      writeEnable_n <= 1'b1;
    end else begin
      ramSelLow_n   <= aHi[ADDR_TOP_BIT];
      ramSelHigh    <= aHi[ADDR_RAM_BIT] && eS;
      writeEnable_n <= !(eS && !rwS);
    end
  end

  // I/O block strobes in the second half of low-address cycles
  assign ioEnable   = !aHi[ADDR_TOP_BIT] && !aHi[ADDR_RAM_BIT] && eS;
  assign blockHit   = ioEnable ? blockDecode(aHi) : '0;
  assign readSwitch = blockHit[SWITCH_SEL] && rwS;
  assign readIdent  = blockHit[IDENT_SEL] && rwS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ioBlockSel_n <= SEL_IDLE_N;
    end else begin
      ioBlockSel_n <= ~blockHit;
    end
  end

  // Read data for the switch and ID strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portOut <= DATA_RST;
      portOe  <= 1'b0;
    end else begin
      portOe <= readSwitch || readIdent;
      if (readSwitch) begin
        portOut <= swS[SWITCH_LOW_W-1:0];
      end else if (readIdent) begin
        portOut <= {idS, swS[SWITCH_W-1:SWITCH_HIGH_LSB]};
      end
    end
  end

  // Serial lamp driver selects, one at a time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lampDriverSel_n <= '1;
    end else begin
      lampDriverSel_n <= ~({{(LAMP_SELS-1){1'b0}}, lampEnS} << lampIdxS);
    end
  end

  // Transmit enable forced low while the processor is in reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txEnable <= 1'b0;
    end else begin
      txEnable <= cpuReset_n && txReqS;
    end
  end

  // Encoder decode
  quad_decode u_quad (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .encoderPhaseA (encoderPhaseA),
    .encoderPhaseB (encoderPhaseB),
    .encStep       (encStep),
    .encDir        (encDir),
    .encCount      (encCount)
  );

  sequence s_ramAddr;
    aHi[ADDR_TOP_BIT:ADDR_RAM_BIT] == RAM_FIELD && eS;
  endsequence

  property p_ramWindow;
    @(posedge mclk) disable iff (!rst_n)
      !ramSelLow_n && ramSelHigh |-> $past(aHi[ADDR_TOP_BIT:ADDR_RAM_BIT]) == RAM_FIELD;
  endproperty
  a_ramWindow: assert property (p_ramWindow)
    else $error("RAM selected outside its window");

  property p_ramSelect;
    @(posedge mclk) disable iff (!rst_n)
      s_ramAddr |=> !ramSelLow_n && ramSelHigh;
  endproperty
  a_ramSelect: assert property (p_ramSelect)
    else $error("RAM not selected inside its window");

  property p_ramHighNeedsE;
    @(posedge mclk) disable iff (!rst_n)
      ramSelHigh |-> $past(eS) && $past(aHi[ADDR_RAM_BIT]);
  endproperty
  a_ramHighNeedsE: assert property (p_ramHighNeedsE)
    else $error("high RAM select without A14 and E");

  property p_writeHalf;
    @(posedge mclk) disable iff (!rst_n)
      !writeEnable_n |-> $past(eS) && !$past(rwS);
  endproperty
  a_writeHalf: assert property (p_writeHalf)
    else $error("write enable outside write second half");

  property p_ioEnable;
    @(posedge mclk) disable iff (!rst_n)
      ioBlockSel_n != SEL_IDLE_N |-> $past(eS)
        && $past(aHi[ADDR_TOP_BIT:ADDR_RAM_BIT]) == 2'h0;
  endproperty
  a_ioEnable: assert property (p_ioEnable)
    else $error("I/O strobe outside low window or E low");

  property p_ioBlock;
    @(posedge mclk) disable iff (!rst_n)
      ioBlockSel_n != SEL_IDLE_N |->
        ioBlockSel_n == ~(8'h01 << $past(aHi[BLOCK_MSB:BLOCK_LSB]));
  endproperty
  a_ioBlock: assert property (p_ioBlock)
    else $error("wrong I/O strobe for address block");

  property p_identByte;
    @(posedge mclk) disable iff (!rst_n)
      portOe && !ioBlockSel_n[IDENT_SEL] |->
        portOut == {$past(idS), $past(swS[SWITCH_W-1:SWITCH_HIGH_LSB])};
  endproperty
  a_identByte: assert property (p_identByte)
    else $error("ident read byte wrong");

  property p_switchByte;
    @(posedge mclk) disable iff (!rst_n)
      portOe && !ioBlockSel_n[SWITCH_SEL] |-> portOut == $past(swS[SWITCH_LOW_W-1:0]);
  endproperty
  a_switchByte: assert property (p_switchByte)
    else $error("switch read byte wrong");

  property p_lampOne;
    @(posedge mclk) disable iff (!rst_n)
      $onehot0(~lampDriverSel_n);
  endproperty
  a_lampOne: assert property (p_lampOne)
    else $error("more than one lamp driver selected");

  property p_txQuiet;
    @(posedge mclk) disable iff (!rst_n)
      !cpuReset_n |=> !txEnable;
  endproperty
  a_txQuiet: assert property (p_txQuiet)
    else $error("transmit enabled during reset");
endmodule : panel_cpu_bus_decode

// [cpu_bus_model.sv]
// Processor side model: free-running E clock and multiplexed bus cycles
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        mclk,
  input  wire logic        req,
  input  wire logic [15:0] reqAddr,
  input  wire logic        reqRead,
  input  wire logic [7:0]  reqData,
  output logic             eClk,
  output logic             addrLatchStrobe,
  output logic             rdWr,
  output logic [7:0]       addrHigh,
  output logic [7:0]       portIn,
  output logic             done
);
  logic [2:0] phase_r = 3'h0;
  logic       act_r   = 1'b0;
  logic [7:0] wData_r = 8'h00;

  // Pin levels at time zero
  initial begin
    eClk = 1'b0;
    addrLatchStrobe = 1'b0;
    rdWr = 1'b1;
    addrHigh = 8'hFF;
    portIn = 8'h00;
    done = 1'b0;
  end

  // Eight mclk per cycle; idle cycles are reads so no stray write occurs
  always @(posedge mclk) begin
    phase_r <= phase_r + 3'h1;
    eClk    <= (phase_r >= 3'h3) && (phase_r <= 3'h6);
    if (phase_r == 3'h7) begin
      addrLatchStrobe <= 1'b1;
      done <= 1'b0;
      act_r <= req && !done;
      rdWr <= (req && !done) ? reqRead : 1'b1;
      if (req && !done) begin
        addrHigh <= reqAddr[15:8];
        portIn <= reqAddr[7:0];
        wData_r <= reqData;
      end
    end
    if (phase_r == 3'h1)
      addrLatchStrobe <= 1'b0;
    // Second half: write data, or released port shows inverted last value
    if (phase_r == 3'h3)
      portIn <= rdWr ? ~portIn : wData_r;
    if (phase_r == 3'h6)
      done <= act_r;
  end
endmodule : cpu_bus_model

// [panel_cpu_bus_decode_test.sv]
// Testbench for the panel processor bus glue
`timescale 1ns/1ps
module panel_cpu_bus_decode_test
  import panel_decode_pkg::*;
;
  localparam int HOLD_SIM = 100;
  logic mclk = 1'b0, rst_n = 1'b0, supplyGood = 1'b1, txEnableReq = 1'b1;
  logic req = 1'b0, reqRead = 1'b1, encA = 1'b0, encB = 1'b0, lampSelActive = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0] reqData = 8'h00;
  logic [1:0] lampSelIdx = 2'h0;
  logic [SWITCH_W-1:0] addrSwitchBits = 10'h3FF;
  logic [IDENT_W-1:0] identBits = 6'h3F;
  logic eClk, addrLatchStrobe, rdWr, done, portOe, cpuReset_n, ramSelLow_n, ramSelHigh;
  logic writeEnable_n, txEnable, encStep, encDir;
  logic [7:0] addrHigh, portIn, portOut, addrLow, encCount, ioBlockSel_n;
  logic [3:0] lampDriverSel_n;
  int errorCnt = 0, nChecks = 0;
  logic lampClk = 1'b0, lampData = 1'b0;
  logic [7:0] lampRx [4] = '{default: 8'h00};

  // Lamp driver model: a driver shifts data in on the rising serial clock while selected
  always @(posedge lampClk)
    for (int k = 0; k < LAMP_SELS; k++)
      if (lampDriverSel_n[k] === 1'b0)
        lampRx[k] <= {lampRx[k][6:0], lampData};

  // Clock and watchdog
  initial forever #5 mclk = ~mclk;
  initial begin
    repeat (90000) @(posedge mclk);
    errorCnt++;
    $display("watchdog expired");
    close_out();
  end

  cpu_bus_model cpu_bus_model_i (.mclk(mclk), .req(req), .reqAddr(reqAddr),
    .reqRead(reqRead), .reqData(reqData), .eClk(eClk),
    .addrLatchStrobe(addrLatchStrobe), .rdWr(rdWr), .addrHigh(addrHigh),
    .portIn(portIn), .done(done));

  panel_cpu_bus_decode #(.HOLD_CYC(HOLD_SIM)) panel_cpu_bus_decode_i (.mclk(mclk),
    .rst_n(rst_n), .supplyGood(supplyGood), .eClk(eClk),
    .addrLatchStrobe(addrLatchStrobe), .rdWr(rdWr), .addrHigh(addrHigh),
    .portIn(portIn), .portOut(portOut), .portOe(portOe), .addrLow(addrLow),
    .cpuReset_n(cpuReset_n), .ramSelLow_n(ramSelLow_n), .ramSelHigh(ramSelHigh),
    .writeEnable_n(writeEnable_n), .ioBlockSel_n(ioBlockSel_n),
    .addrSwitchBits(addrSwitchBits), .identBits(identBits), .lampSelIdx(lampSelIdx),
    .lampSelActive(lampSelActive), .lampDriverSel_n(lampDriverSel_n),
    .txEnableReq(txEnableReq), .txEnable(txEnable), .encoderPhaseA(encA),
    .encoderPhaseB(encB), .encStep(encStep), .encDir(encDir), .encCount(encCount));

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wait_e(input logic v);
    int g;
    g = 0;
    while (eClk !== v && g < 20) begin
      @(posedge mclk);
      g++;
    end
    chk("eClk phase", 16'(v), 16'(eClk));
  endtask : wait_e

  // One bus cycle; checks both halves of the decode
  task bus(input logic [15:0] a, input logic rd, input logic [7:0] wd, output logic [7:0] d);
    logic [7:0] sel;
    int g;
    wait_e(1'b1);
    wait_e(1'b0);
    reqAddr <= a;
    reqRead <= rd;
    reqData <= wd;
    req <= 1'b1;
    @(posedge mclk);
    wait_e(1'b1);
    wait_e(1'b0);
    wait_e(1'b1);
    chk("ramSelHigh low half", 16'h0, 16'(ramSelHigh));
    chk("writeEnable_n low half", 16'h1, 16'(writeEnable_n));
    chk("ioBlockSel_n low half", 16'h00FF, 16'(ioBlockSel_n));
    g = 0;
    while (done !== 1'b1 && g < 20) begin
      @(posedge mclk);
      g++;
    end
    chk("bus done", 16'h1, 16'(done));
    req <= 1'b0;
    d = portOut;
    sel = (a[15:14] == 2'h0) ? ~(8'h01 << a[13:11]) : 8'hFF;
    chk("ramSelLow_n", 16'(a[15]), 16'(ramSelLow_n));
    chk("ramSelHigh", 16'(a[14]), 16'(ramSelHigh));
    chk("writeEnable_n", 16'(rd), 16'(writeEnable_n));
    chk("ioBlockSel_n", 16'(sel), 16'(ioBlockSel_n));
    chk("addrLow", 16'(a[7:0]), 16'(addrLow));
  endtask : bus

  // Waits for reset release, counting E rises and watching transmit enable
  task wait_rel(output int n, output int g, output logic txBad);
    logic eLast;
    n = 0;
    g = 0;
    txBad = 1'b0;
    eLast = eClk;
    while (cpuReset_n !== 1'b1 && g < 40000) begin
      if (txEnable !== 1'b0)
        txBad = 1'b1;
      @(posedge mclk);
      g++;
      if (eClk === 1'b1 && eLast === 1'b0)
        n++;
      eLast = eClk;
    end
  endtask : wait_rel

  task t_reset;
    int n, g;
    logic txBad;
    repeat (19) @(posedge mclk);
    chk("cpuReset_n in reset", 16'h0, 16'(cpuReset_n));
    chk("txEnable in reset", 16'h0, 16'(txEnable));
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_rel(n, g, txBad);
    chk("cpuReset_n released", 16'h1, 16'(cpuReset_n));
    chk("E rises at release", 16'h1, 16'(n >= E_RESET_CYCLES));
    chk("txEnable before release", 16'h0, 16'(txBad));
    repeat (6) @(posedge mclk);
    chk("txEnable on", 16'h1, 16'(txEnable));
    txEnableReq <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("txEnable off", 16'h0, 16'(txEnable));
    txEnableReq <= 1'b1;
    supplyGood <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("cpuReset_n supply lost", 16'h0, 16'(cpuReset_n));
    repeat (20) @(posedge mclk);
    supplyGood <= 1'b1;
    wait_rel(n, g, txBad);
    chk("cpuReset_n back", 16'h1, 16'(cpuReset_n));
    chk("E rises after supply", 16'h1, 16'(n >= E_RESET_CYCLES));
    chk("hold after supply", 16'h1, 16'(g >= HOLD_SIM));
    chk("txEnable in supply reset", 16'h0, 16'(txBad));
    $display("test reset done");
  endtask : t_reset

  task t_ram;
    logic [15:0] adr [6];
    logic [7:0] d;
    adr = '{16'h4000, 16'h6123, 16'h7FFF, 16'h8000, 16'hC001, 16'h1800};
    for (int i = 0; i < 12; i++)
      bus(adr[i/2], 1'(i % 2), 8'(8'h5A + i), d);
    $display("test ram done");
  endtask : t_ram

  task t_io;
    logic [7:0] d;
    for (int k = 0; k < 16; k++)
      bus(16'((k / 2) * 16'h0800 + (k % 2) * 16'h07FF), 1'b1, 8'h00, d);
    $display("test io done");
  endtask : t_io

  task t_switch;
    logic [7:0] d;
    addrSwitchBits <= 10'h2A5;
    identBits <= 6'h2C;
    bus(16'h3000, 1'b1, 8'h00, d);
    chk("switch byte", 16'h00A5, 16'(d));
    chk("portOe", 16'h1, 16'(portOe));
    bus(16'h3805, 1'b1, 8'h00, d);
    chk("ident byte", 16'h00B2, 16'(d));
    $display("test switch done");
  endtask : t_switch

  task t_lamp;
    logic [3:0] exp;
    logic [7:0] pat;
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      lampSelIdx <= 2'(i);
      lampSelActive <= (i < 4);
      exp = (i < 4) ? ~(4'h1 << i) : 4'hF;
      pat = 8'(8'h30 + i);
      repeat (5) @(posedge mclk);
      chk("lampDriverSel_n", 16'(exp), 16'(lampDriverSel_n));
      // Serial byte, data set one edge before each rising serial clock
      for (int b = 7; b >= 0; b--) begin
        lampData <= pat[b];
        lampClk <= 1'b0;
        @(posedge mclk);
        lampClk <= 1'b1;
        @(posedge mclk);
      end
      lampClk <= 1'b0;
      for (int k = 0; k < 4; k++)
        chk("lampRx", 16'((k <= i) ? 8'(8'h30 + k) : 8'h00), 16'(lampRx[k]));
    end
    $display("test lamp done");
  endtask : t_lamp

  // Drives one encoder state and reports at which cycle a step pulse shows
  task enc_set(input logic [1:0] v, output int hit);
    @(posedge mclk);
    {encA, encB} <= v;
    hit = 0;
    for (int j = 1; j <= 6; j++) begin
      @(posedge mclk);
      #1;
      if (encStep === 1'b1 && hit == 0)
        hit = j;
    end
  endtask : enc_set

  task t_enc;
    logic [1:0] up [4];
    logic [7:0] c0;
    int hit;
    up = '{2'h1, 2'h3, 2'h2, 2'h0};
    c0 = 8'h00;
    for (int i = 0; i < 8; i++) begin
      enc_set((i < 4) ? up[i] : up[2'(6 - i)], hit);
      chk("encStep delay", 16'h3, 16'(hit));
      chk("encDir", 16'(i < 4), 16'(encDir));
      if (i == 3)
        chk("encCount up", 16'(c0 + 8'h04), 16'(encCount));
    end
    chk("encCount back", 16'(c0), 16'(encCount));
    enc_set(2'h3, hit);
    chk("both phases", 16'h0, 16'(hit));
    $display("test encoder done");
  endtask : t_enc

  task close_out;
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    t_reset();
    t_ram();
    t_io();
    t_switch();
    t_lamp();
    t_enc();
    close_out();
  end
endmodule : panel_cpu_bus_decode_test
